/* File: inc/qenc_consts.svh */
// Named constants for the quadrature square-wave encoder output block
`ifndef QENC_CONSTS_SVH
`define QENC_CONSTS_SVH
// Clock rate in MHz
`define QENC_CLK_MHZ        100
// Least fault indication low time in microseconds
`define QENC_FAULT_TIME_US  20000
// Fault low time in clock cycles, exact (integer product)
`define QENC_FAULT_CYCLES   (`QENC_FAULT_TIME_US * `QENC_CLK_MHZ)
// Quadrature phase codes, Gray along the forward path
`define QENC_PH0            2'h0
`define QENC_PH1            2'h1
`define QENC_PH2            2'h3
`define QENC_PH3            2'h2
`endif

/* File: inc/qenc_pkg.sv */
// Types shared by the quadrature square-wave encoder output block
`include "qenc_consts.svh"
package qenc_pkg;
    // Quadrature phase: {first, second} = 00, 10, 11, 01 going forward
    typedef enum logic [1:0] {
        QENC_PH_LL = `QENC_PH0,
        QENC_PH_HL = `QENC_PH1,
        QENC_PH_HH = `QENC_PH2,
        QENC_PH_LH = `QENC_PH3
    } qenc_phase_t;
endpackage

/* File: src/qenc_encoder.sv */
// Quadrature square-wave encoder output stage with reference and fault lines
//
// Behaviour
// [R1] Two square-wave channels a quarter signal period apart encode the position.
// [R2] Forward motion makes the second channel lag the first; reverse swaps them.
// [R3] Reference pulse only while both channels sit in one defined state.
// [R4] Reference pulse lasts one quarter period, one quadrature state.
// [R5] Each channel and the reference pulse also leave as a complement.
// [R6] Fault line high when healthy, low at least 20 ms on fault; optional hi-z.
// [R7] Supply loss or light source failure raises the fault indication.
// [R8] Receiver counts one step per evaluated edge, 1, 2 or 4 fold; the model counts every edge of both channels, 4 fold only.
// [R9] Receiver catches every edge down to the least edge separation.
// [R10] Receiver synchronises channels, counts up when second lags, down when it leads.
`include "qenc_consts.svh"

module qenc_encoder
    import qenc_pkg::*;
#(
    parameter int FAULT_CYCLES = `QENC_FAULT_CYCLES,
    parameter bit HIZ_ON_FAULT = 1'b0
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic step_req,
    input  wire logic step_fwd,
    input  wire logic ref_zone,
    input  wire logic supply_loss,
    input  wire logic light_fail,
    output logic      quad_chan_first,
    output logic      quad_chan_first_n,
    output logic      quad_chan_second,
    output logic      quad_chan_second_n,
    output logic      quad_oe,
    output logic      ref_pulse,
    output logic      ref_pulse_n,
    output logic      fault_n
);

    // ************************************************************
    // Parameter checks
    // ************************************************************
    if (FAULT_CYCLES < 1) begin : g_bad_fault
        $error("FAULT_CYCLES must be at least one");
    end

    localparam int CW = $clog2(FAULT_CYCLES + 1);
    localparam logic [CW-1:0] FAULT_LOAD = CW'(FAULT_CYCLES - 1);

    // Channel levels of a phase, {first, second}
    function automatic logic [1:0] qenc_levels(input qenc_phase_t ph);
        case (ph)
            QENC_PH_LL: qenc_levels = 2'b00;
            QENC_PH_HL: qenc_levels = 2'b10;
            QENC_PH_HH: qenc_levels = 2'b11;
            default:    qenc_levels = 2'b01;
        endcase
    endfunction

    // ************************************************************
    // Quadrature phase sequencer
    // ************************************************************
    qenc_phase_t phase_q;
    qenc_phase_t phase_d;

    // One state per step, forward or backward
    always_comb begin
        phase_d = phase_q;
        if (step_req) begin
            case (phase_q)
                QENC_PH_LL: phase_d = step_fwd ? QENC_PH_HL : QENC_PH_LH; // [R1] [R2]
                QENC_PH_HL: phase_d = step_fwd ? QENC_PH_HH : QENC_PH_LL; // [R1] [R2]
                QENC_PH_HH: phase_d = step_fwd ? QENC_PH_LH : QENC_PH_HL; // [R1] [R2]
                default:    phase_d = step_fwd ? QENC_PH_LL : QENC_PH_HH; // [R1] [R2]
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_q <= QENC_PH_LL;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ************************************************************
    // Fault hold timer
    // ************************************************************
    logic [CW-1:0] fault_cnt_q;
    logic [CW-1:0] fault_cnt_d;
    logic          malfunction;
    logic          fault_active;

    // Reload on any malfunction, then hold low for the full time
    always_comb begin
        malfunction  = supply_loss | light_fail;                  // [R7]
        fault_active = malfunction | (fault_cnt_q != '0);         // [R6]
        if (malfunction) begin
            fault_cnt_d = FAULT_LOAD;                             // [R6]
        end else if (fault_cnt_q != '0) begin
            fault_cnt_d = fault_cnt_q - CW'(1);
        end else begin
            fault_cnt_d = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fault_cnt_q <= '0;
        end else begin
            fault_cnt_q <= fault_cnt_d;
        end
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    logic [1:0] lv_d;
    logic       ref_d;
    logic       oe_d;

    // Outputs follow the next phase so all lines switch together
    always_comb begin
        lv_d  = qenc_levels(phase_d);
        ref_d = ref_zone && (phase_d == QENC_PH_HH);              // [R3] [R4]
        oe_d  = !(HIZ_ON_FAULT && fault_active);                  // [R6]
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            quad_chan_first    <= 1'b0;
            quad_chan_first_n  <= 1'b1;
            quad_chan_second   <= 1'b0;
            quad_chan_second_n <= 1'b1;
            quad_oe            <= 1'b1;
            ref_pulse          <= 1'b0;
            ref_pulse_n        <= 1'b1;
            fault_n            <= 1'b1;
        end else begin
            quad_chan_first    <= lv_d[1];
            quad_chan_first_n  <= ~lv_d[1];                       // [R5]
            quad_chan_second   <= lv_d[0];
            quad_chan_second_n <= ~lv_d[0];                       // [R5]
            quad_oe            <= oe_d;
            ref_pulse          <= ref_d;
            ref_pulse_n        <= ~ref_d;                         // [R5]
            fault_n            <= ~fault_active;                  // [R6] [R7]
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    int low_cnt_q;

    // Helper: length of the current fault low time
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            low_cnt_q <= 0;
        end else if (!fault_n) begin
            low_cnt_q <= low_cnt_q + 1;
        end else begin
            low_cnt_q <= 0;
        end
    end

    property p_one_edge;
        @(posedge clock) disable iff (!rst_n)
        !($changed(quad_chan_first) && $changed(quad_chan_second));
    endproperty
    a_one_edge: assert property (p_one_edge) else $error("both channels moved at once"); // [R1]

    property p_fwd_order;
        @(posedge clock) disable iff (!rst_n)
        (step_req && step_fwd) |=>
            ($rose(quad_chan_first) && !quad_chan_second) ||
            ($rose(quad_chan_second) && quad_chan_first) ||
            ($fell(quad_chan_first) && quad_chan_second) ||
            ($fell(quad_chan_second) && !quad_chan_first);
    endproperty
    a_fwd_order: assert property (p_fwd_order) else $error("forward step wrong order"); // [R2]

    property p_rev_order;
        @(posedge clock) disable iff (!rst_n)
        (step_req && !step_fwd) |=>
            ($rose(quad_chan_second) && !quad_chan_first) ||
            ($rose(quad_chan_first) && quad_chan_second) ||
            ($fell(quad_chan_second) && quad_chan_first) ||
            ($fell(quad_chan_first) && !quad_chan_second);
    endproperty
    a_rev_order: assert property (p_rev_order) else $error("reverse step wrong order"); // [R2]

    property p_ref_gated;
        @(posedge clock) disable iff (!rst_n)
        ref_pulse |-> (quad_chan_first && quad_chan_second);
    endproperty
    a_ref_gated: assert property (p_ref_gated) else $error("reference pulse not gated"); // [R3]

    property p_ref_width;
        @(posedge clock) disable iff (!rst_n)
        $fell(ref_pulse) |->
            ($changed(quad_chan_first) || $changed(quad_chan_second) || !$past(ref_zone));
    endproperty
    a_ref_width: assert property (p_ref_width) else $error("reference pulse width wrong"); // [R4]

    property p_compl;
        @(posedge clock) disable iff (!rst_n)
        (quad_chan_first_n == !quad_chan_first) && (quad_chan_second_n == !quad_chan_second)
            && (ref_pulse_n == !ref_pulse);
    endproperty
    a_compl: assert property (p_compl) else $error("complement line mismatch"); // [R5]

    property p_fault_len;
        @(posedge clock) disable iff (!rst_n)
        $rose(fault_n) |-> (low_cnt_q >= FAULT_CYCLES);
    endproperty
    a_fault_len: assert property (p_fault_len) else $error("fault low pulse too short"); // [R6]

    property p_fault_set;
        @(posedge clock) disable iff (!rst_n)
        (supply_loss || light_fail) |=> !fault_n ##0 (quad_oe == !HIZ_ON_FAULT);
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("malfunction not flagged"); // [R7]

    property p_oe_float;
        @(posedge clock) disable iff (!rst_n)
        quad_oe == !(HIZ_ON_FAULT && !fault_n);
    endproperty
    a_oe_float: assert property (p_oe_float) else $error("output enable off fault"); // [R6]

endmodule

/* File: tb/qenc_rx_model.sv */
// Receiving counter model that decodes the quadrature channels
module qenc_rx_model (
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               chan_a,
    input  wire logic               chan_b,
    output logic signed [15:0]      pos_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        [1:0]  sync_a_q;
    logic        [1:0]  sync_b_q;
    logic               prev_a_q;
    logic               prev_b_q;
    logic signed [15:0] pos_d;
    // One step per channel edge, direction from old and new phase
    always_comb begin
        pos_d = pos_q;
        if ((sync_a_q[1] ^ prev_a_q) || (sync_b_q[1] ^ prev_b_q)) begin
            if (sync_a_q[1] ^ prev_b_q) begin
                pos_d = pos_q + 16'sh0001;
            end else begin
                pos_d = pos_q - 16'sh0001;
            end
        end
    end
    // Two-flop synchroniser, then edge history and count
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync_a_q <= 2'h0;
            sync_b_q <= 2'h0;
            prev_a_q <= 1'b0;
            prev_b_q <= 1'b0;
            pos_q    <= 16'sh0000;
        end else begin
            sync_a_q <= {sync_a_q[0], chan_a};
            sync_b_q <= {sync_b_q[0], chan_b};
            prev_a_q <= sync_a_q[1];
            prev_b_q <= sync_b_q[1];
            pos_q    <= pos_d;
        end
    end
endmodule

/* File: tb/qenc_encoder_tb.sv */
// Testbench for the quadrature encoder output stage
module qenc_encoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FCYC = 16;
    logic clock = 1'b0, rst_n = 1'b0, step_req = 1'b0, step_fwd = 1'b0;
    logic ref_zone = 1'b0, supply_loss = 1'b0, light_fail = 1'b0;
    logic qa, qa_n, qb, qb_n, q_oe, rp, rp_n, fault_n;
    logic signed [15:0] rx_pos;
    int   err_total = 0, total_checks = 0, ph = 0, exp_pos = 0;
    // Clock and instances
    always #5 clock = ~clock;
    qenc_encoder #(.FAULT_CYCLES(FCYC), .HIZ_ON_FAULT(1'b1)) dut_u (.clock(clock),
        .rst_n(rst_n), .step_req(step_req), .step_fwd(step_fwd), .ref_zone(ref_zone),
        .supply_loss(supply_loss), .light_fail(light_fail), .quad_chan_first(qa),
        .quad_chan_first_n(qa_n), .quad_chan_second(qb), .quad_chan_second_n(qb_n),
        .quad_oe(q_oe), .ref_pulse(rp), .ref_pulse_n(rp_n), .fault_n(fault_n));
    qenc_rx_model rx_u (.clock(clock), .rst_n(rst_n), .chan_a(qa), .chan_b(qb), .pos_q(rx_pos));
    // Compare and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Reset for 16 cycles, then idle levels
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        ph = 0;
        exp_pos = 0;
        @(negedge clock);
        chk({qa, qa_n, qb, qb_n, rp, rp_n, fault_n, q_oe}, 16'h0057);
    endtask
    // Back-to-back steps with channel, complement and reference checks
    task automatic t_walk(input logic fwd, input logic zone, input int n);
        logic e_a, e_b, e_r;
        step_req = 1'b1;
        step_fwd = fwd;
        ref_zone = zone;
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            ph = (ph + (fwd ? 1 : 3)) % 4;
            exp_pos += fwd ? 1 : -1;
            e_a = (ph == 1) || (ph == 2);
            e_b = (ph >= 2);
            e_r = zone && (ph == 2);
            chk({qa, qa_n, qb, qb_n}, {12'h000, e_a, ~e_a, e_b, ~e_b});
            chk({rp, rp_n}, {14'h0000, e_r, ~e_r});
        end
        step_req = 1'b0;
        repeat (4) @(negedge clock);
        chk(rx_pos, exp_pos[15:0]);
    endtask
    // One-cycle malfunction, then fault low time and output float
    task automatic t_fault(input logic src);
        int lo;
        lo = 0;
        supply_loss = ~src;
        light_fail = src;
        @(negedge clock);
        supply_loss = 1'b0;
        light_fail = 1'b0;
        chk({15'h0000, fault_n}, 16'h0000);
        if (fault_n === 1'b0) lo++;
        for (int i = 0; i < 40 && !(lo > 0 && fault_n === 1'b1); i++) begin
            @(negedge clock);
            if (fault_n === 1'b0) lo++;
            chk({15'h0000, q_oe}, {15'h0000, fault_n});
        end
        if (fault_n !== 1'b1) begin
            chk({15'h0000, fault_n}, 16'h0001);
            end_sim();
        end
        chk(lo[15:0], FCYC[15:0]);
    endtask
    // Main sequence
    initial begin
        t_reset();
        t_walk(1'b1, 1'b1, 9);
        t_walk(1'b0, 1'b1, 6);
        t_walk(1'b1, 1'b0, 3);
        t_fault(1'b0);
        t_fault(1'b1);
        t_reset();
        t_walk(1'b0, 1'b0, 5);
        end_sim();
    end
endmodule
